// File: hdl/lctg_guard.sv
`timescale 1ns/1ps
`include "lctg_map.svh"
// Overview of operation
// R1 - Wait refresh recovery after auto refresh before ACTIVE or refresh.
// R2 - Wait activate-to-access after ACTIVE, and precharge period after PRECHARGE.
// R3 - Space ACTIVEs to different banks by the bank-to-bank delay.
// R4 - Write recovery after last write data before precharge, at least one cycle.
// R5 - Auto-precharge write total is ceil write recovery plus ceil precharge.
// R6 - Wait one cycle after internal write before READ.
// R7 - After self refresh exit, no command for 120 ns with clocks running.
// R8 - After power-down exit, wait the exit delay with a clock pulse inside.
// R9 - Hold each clock-enable level at least one cycle.
// R10 - Issue refreshes at an average interval no longer than 7.8 us.
// R11 - At most eight refreshes owed; gap never exceeds eight intervals.
// R12 - Status read: two cycles after mode command, then latency plus one.
// R13 - Device returns read data at the programmed read latency.
// R14 - Change clock frequency only in power-down or self refresh.
// R15 - Keep a row open at least 40 ns and at most 70000 ns.
// R16 - Wait two cycles after mode register set.
// R17 - Per-bank and global down-counters block commands until they expire.
module lctg_guard #(
   parameter int BANKS         = 4,
   parameter int READ_LATENCY  = 3,
   parameter int REFI_CYC      = `LCTG_FLOOR(`LCTG_AVG_REFRESH_NS),
   parameter int RAS_MAX_CYC   = `LCTG_FLOOR(`LCTG_ACT_TO_PRE_MAX_NS)
) (
   // Clock and reset.
   input  wire logic               clk,
   input  wire logic               sys_rst,
   // User request port.
   input  wire lctg_pkg::lctg_req_s req,
   input  wire logic               req_valid,
   output logic                    req_ready,
   // Status toward the user.
   output logic                    refresh_urgent,
   output logic                    row_timeout,
   output logic                    freq_change_ok,
   output logic                    rdata_valid,
   // Memory command pins.
   output lctg_pkg::lctg_pins_s    pins,
   // Read strobe returned by the memory side.
   input  wire logic               mem_rdata_strobe
);
   localparam int RFC  = `LCTG_CEIL(`LCTG_REFRESH_RECOVERY_NS);
   localparam int RCD  = `LCTG_CEIL(`LCTG_ACT_TO_ACCESS_NS);
   localparam int RP   = `LCTG_CEIL(`LCTG_PRECHARGE_NS);
   localparam int RRD  = `LCTG_CEIL(`LCTG_ACT_TO_ACT_NS);
   localparam int WR   = (`LCTG_CEIL(`LCTG_WRITE_RECOVERY_NS) < 1) ? 1 :
                         `LCTG_CEIL(`LCTG_WRITE_RECOVERY_NS);
   localparam int DAL  = WR + RP;
   localparam int XSR  = `LCTG_CEIL(`LCTG_SELF_REFRESH_EXIT_NS);
   localparam int RAS  = `LCTG_CEIL(`LCTG_ACT_TO_PRE_MIN_NS);
   localparam int CW   = 8;
   localparam int RW   = 32;
   localparam int OW   = 4;

   initial begin
      if (BANKS != 4 || READ_LATENCY < 2 || READ_LATENCY > 3 || REFI_CYC < 2 ||
          RAS_MAX_CYC <= RAS)
         $error("lctg_guard: unsupported parameter values");
   end

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001, ST_PDOWN = 3'b010, ST_SREF = 3'b100
   } lctg_pwr_e;

   lctg_pwr_e              pwr_r, pwr_nxt;
   logic [CW-1:0]          glob_r, rrd_r, cke_r, wtr_r;
   logic [CW-1:0]          bank_r [BANKS];
   logic [CW-1:0]          ras_r  [BANKS];
   logic [RW-1:0]          rowage_r [BANKS];
   logic [BANKS-1:0]       open_r;
   logic [RW-1:0]          refi_r;
   logic [OW-1:0]          owed_r;
   logic                   strb_s1_r, strb_s2_r;
   lctg_pkg::lctg_req_s    req_r;

   wire lctg_pkg::lctg_cmd_e cmd  = req.cmd;
   wire [1:0]                bk   = req.bank;
   wire is_act   = cmd == lctg_pkg::LCTG_ACT;
   wire is_rd    = cmd == lctg_pkg::LCTG_RD || cmd == lctg_pkg::LCTG_SRR;
   wire is_wr    = cmd == lctg_pkg::LCTG_WR || cmd == lctg_pkg::LCTG_WRA;
   // A status read returns a register, not array data, so it needs no open row.
   wire is_acc   = is_wr || cmd == lctg_pkg::LCTG_RD;
   wire is_pre   = cmd == lctg_pkg::LCTG_PRE;
   wire is_ref   = cmd == lctg_pkg::LCTG_REF;
   wire is_cke   = cmd inside {lctg_pkg::LCTG_SRE, lctg_pkg::LCTG_SRX,
                               lctg_pkg::LCTG_PDE, lctg_pkg::LCTG_PDX};
   wire bank_ok  = bank_r[bk] == '0;
   wire pwr_ok   = (pwr_r == ST_IDLE) ? !(cmd inside {lctg_pkg::LCTG_SRX,
                   lctg_pkg::LCTG_PDX}) : (pwr_r == ST_PDOWN) ?
                   cmd == lctg_pkg::LCTG_PDX : cmd == lctg_pkg::LCTG_SRX;
   wire legal    = glob_r == '0 && pwr_ok &&                            // R17
                   (!is_act || (rrd_r == '0 && bank_ok && !open_r[bk])) &&  // R2 R3
                   (!is_acc || (bank_ok && open_r[bk])) &&              // R2
                   (!is_rd || wtr_r == '0) &&                          // R6
                   (!is_pre || (bank_ok && ras_r[bk] == '0)) &&        // R4 R15
                   (!is_cke || cke_r == '0) &&                         // R9
                   (!(is_ref || cmd == lctg_pkg::LCTG_SRE) || open_r == '0);
   // Refresh has priority once seven refreshes are owed so the posted limit is never passed.
   wire ref_hold = owed_r >= OW'(`LCTG_MAX_POSTED - 1) && !is_ref;     // R11
   wire take     = req_valid && req_ready && legal && !ref_hold;
   wire any_old  = |{rowage_r[0] >= RW'(RAS_MAX_CYC), rowage_r[1] >= RW'(RAS_MAX_CYC),
                     rowage_r[2] >= RW'(RAS_MAX_CYC), rowage_r[3] >= RW'(RAS_MAX_CYC)};

   always_comb begin
      case (pwr_r)
         ST_IDLE:  pwr_nxt = (take && cmd == lctg_pkg::LCTG_SRE) ? ST_SREF :
                             (take && cmd == lctg_pkg::LCTG_PDE) ? ST_PDOWN : ST_IDLE;
         ST_PDOWN: pwr_nxt = (take && cmd == lctg_pkg::LCTG_PDX) ? ST_IDLE : ST_PDOWN;
         ST_SREF:  pwr_nxt = (take && cmd == lctg_pkg::LCTG_SRX) ? ST_IDLE : ST_SREF;
         default:  pwr_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pwr_r <= ST_IDLE;
         req_ready <= 1'b0;
      end else begin
         pwr_r <= pwr_nxt;
         req_ready <= 1'b1;
      end
   end

   // Global spacing counter loaded by the command just issued.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         glob_r <= '0;
      end else if (take) begin
         case (cmd)
            lctg_pkg::LCTG_REF: glob_r <= CW'(RFC - 1);                      // R1
            lctg_pkg::LCTG_SRX: glob_r <= CW'(XSR - 1);                      // R7
            lctg_pkg::LCTG_PDX: glob_r <= CW'(`LCTG_PD_EXIT_CYC - 1);         // R8
            lctg_pkg::LCTG_MRS: glob_r <= CW'(`LCTG_MODE_SET_CYC - 1);        // R16
            lctg_pkg::LCTG_SRR: glob_r <= CW'(READ_LATENCY);                 // R12
            default:            glob_r <= '0;
         endcase
      end else if (glob_r != '0) begin
         glob_r <= glob_r - CW'(1);
      end
   end

   // The mode command of a status read is issued as MODE_REGISTER_SET, which covers the
   // two-cycle gap to the following status read itself.                R12
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rrd_r <= '0;
         cke_r <= '0;
         wtr_r <= '0;
      end else begin
         rrd_r <= (take && is_act) ? CW'(RRD - 1) : (rrd_r != '0) ? rrd_r - CW'(1) : '0;
         cke_r <= (take && is_cke) ? CW'(`LCTG_CKE_MIN_CYC) :
                  (cke_r != '0) ? cke_r - CW'(1) : '0;                         // R9
         wtr_r <= (take && is_wr) ? CW'(`LCTG_WTR_CYC + 1) :
                  (wtr_r != '0) ? wtr_r - CW'(1) : '0;                         // R6
      end
   end

   for (genvar b = 0; b < BANKS; b++) begin : g_bank
      wire hit = take && (bk == 2'(b) || cmd == lctg_pkg::LCTG_REF);
      always_ff @(posedge clk or posedge sys_rst) begin
         if (sys_rst) begin
            bank_r[b]   <= '0;
            ras_r[b]    <= '0;
            rowage_r[b] <= '0;
            open_r[b]   <= 1'b0;
         end else begin
            if (hit && is_act) begin
               bank_r[b] <= CW'(RCD - 1);                                    // R2
               ras_r[b]  <= CW'(RAS - 1);                                    // R15
               open_r[b] <= 1'b1;
            end else if (hit && cmd == lctg_pkg::LCTG_WRA) begin
               bank_r[b] <= CW'(DAL - 1);                                    // R5
               open_r[b] <= 1'b0;
            end else if (hit && cmd == lctg_pkg::LCTG_WR) begin
               bank_r[b] <= '0;
               ras_r[b]  <= (ras_r[b] > CW'(WR)) ? ras_r[b] : CW'(WR);       // R4
            end else if (hit && is_pre) begin
               bank_r[b] <= CW'(RP - 1);                                     // R2
               open_r[b] <= 1'b0;
            end else begin
               if (bank_r[b] != '0) bank_r[b] <= bank_r[b] - CW'(1);       // R17
               if (ras_r[b] != '0) ras_r[b] <= ras_r[b] - CW'(1);
            end
            rowage_r[b] <= (open_r[b] && !(hit && is_act)) ? rowage_r[b] + RW'(1) : '0;
         end
      end
   end

   // Refresh debt: one owed per interval, one paid per refresh issued.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         refi_r <= '0;
         owed_r <= '0;
      end else begin
         refi_r <= (refi_r == RW'(REFI_CYC - 1)) ? '0 : refi_r + RW'(1);     // R10
         if (pwr_r == ST_SREF) begin
            owed_r <= '0;
         end else if (refi_r == RW'(REFI_CYC - 1) && !(take && is_ref)) begin
            owed_r <= (owed_r == OW'(`LCTG_MAX_POSTED)) ? owed_r : owed_r + OW'(1);
         end else if (!(refi_r == RW'(REFI_CYC - 1)) && take && is_ref && owed_r != '0) begin
            owed_r <= owed_r - OW'(1);                                       // R11
         end
      end
   end

   // Read data strobe comes from the memory domain; two flops before use.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         strb_s1_r <= 1'b0;
         strb_s2_r <= 1'b0;
      end else begin
         strb_s1_r <= mem_rdata_strobe;
         strb_s2_r <= strb_s1_r;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pins           <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                             cke: 1'b1, ap: 1'b0, ba: 2'h0};
         refresh_urgent <= 1'b0;
         row_timeout    <= 1'b0;
         freq_change_ok <= 1'b0;
         rdata_valid    <= 1'b0;
         req_r          <= '{cmd: lctg_pkg::LCTG_NOP, bank: 2'h0};
      end else begin
         req_r          <= take ? req : '{cmd: lctg_pkg::LCTG_NOP, bank: 2'h0};
         pins.ba        <= bk;
         pins.ap        <= take && cmd == lctg_pkg::LCTG_WRA;
         pins.cs_n      <= !(take && !is_cke) &&
                           !(take && cmd inside {lctg_pkg::LCTG_SRE});
         pins.ras_n     <= !(take && (is_act || is_pre || is_ref ||
                           cmd inside {lctg_pkg::LCTG_MRS, lctg_pkg::LCTG_SRE}));
         pins.cas_n     <= !(take && (is_rd || is_wr || is_ref ||
                           cmd inside {lctg_pkg::LCTG_MRS, lctg_pkg::LCTG_SRE}));
         pins.we_n      <= !(take && (is_wr || is_pre || cmd == lctg_pkg::LCTG_MRS));
         pins.cke       <= pwr_nxt == ST_IDLE;
         refresh_urgent <= owed_r >= OW'(`LCTG_MAX_POSTED - 1);                 // R11
         row_timeout    <= any_old;                                             // R15
         freq_change_ok <= pwr_r != ST_IDLE;                                    // R14
         rdata_valid    <= strb_s2_r;                                           // R13
      end
   end
endmodule : lctg_guard

// File: hdl/lctg_map.svh
`ifndef LCTG_MAP_SVH
`define LCTG_MAP_SVH
// Times in ns unless noted; cycle counts derive from the 10 ns clock.
`define LCTG_CLK_PERIOD_NS        10
`define LCTG_REFRESH_RECOVERY_NS  72
`define LCTG_ACT_TO_ACCESS_NS     15
`define LCTG_PRECHARGE_NS         15
`define LCTG_ACT_TO_ACT_NS        10
`define LCTG_WRITE_RECOVERY_NS    15
`define LCTG_SELF_REFRESH_EXIT_NS 120
`define LCTG_ACT_TO_PRE_MIN_NS    40
`define LCTG_ACT_TO_PRE_MAX_NS    70000
`define LCTG_AVG_REFRESH_NS       7800
`define LCTG_MAX_POSTED           8
`define LCTG_WTR_CYC              1
`define LCTG_PD_EXIT_CYC          2
`define LCTG_CKE_MIN_CYC          1
`define LCTG_MODE_SET_CYC         2
`define LCTG_SRR_TO_READ_CYC      2
`define LCTG_CEIL(ns) (((ns) + `LCTG_CLK_PERIOD_NS - 1) / `LCTG_CLK_PERIOD_NS)
`define LCTG_FLOOR(ns) ((ns) / `LCTG_CLK_PERIOD_NS)
`endif

// File: hdl/lctg_pkg.sv
package lctg_pkg;
   typedef enum logic [3:0] {
      LCTG_NOP = 4'h0, LCTG_ACT = 4'h1, LCTG_RD = 4'h2, LCTG_WR = 4'h3,
      LCTG_WRA = 4'h4, LCTG_PRE = 4'h5, LCTG_REF = 4'h6, LCTG_SRE = 4'h7,
      LCTG_SRX = 4'h8, LCTG_PDE = 4'h9, LCTG_PDX = 4'hA, LCTG_MRS = 4'hB,
      LCTG_SRR = 4'hC
   } lctg_cmd_e;
   typedef struct packed {
      lctg_cmd_e  cmd;
      logic [1:0] bank;
   } lctg_req_s;
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic cke;
      logic ap;
      logic [1:0] ba;
   } lctg_pins_s;
endpackage : lctg_pkg

// File: tb/lctg_guard_props.sv
`timescale 1ns/1ps
module lctg_guard_props (
   // Clock and reset.
   input wire logic                 clk,
   input wire logic                 sys_rst,
   // Watched ports.
   input wire logic                 refresh_urgent,
   input wire logic                 freq_change_ok,
   input wire logic                 rdata_valid,
   input wire lctg_pkg::lctg_pins_s pins,
   input wire logic                 mem_rdata_strobe
);
   wire logic [3:0] code_w = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
   wire logic       is_cmd = !pins.cs_n;
   wire logic       is_act = code_w == 4'h3;
   wire logic       is_rd  = code_w == 4'h5;
   wire logic       is_wr  = code_w == 4'h4;
   wire logic       is_pre = code_w == 4'h2;
   wire logic       is_mrs = code_w == 4'h0;
   wire logic       is_ref = code_w == 4'h1 && pins.cke;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence no_act_ref_s; !(is_act || is_ref) [*7]; endsequence
   sequence quiet_s; !is_cmd; endsequence
   ref_spacing_a: assert property (is_ref |=> no_act_ref_s)
      else $error("refresh spacing violated");
   act_access_a: assert property (is_act |=> !(is_rd || is_wr))
      else $error("access too soon after activate");
   pre_act_a: assert property (is_pre |=> !is_act)
      else $error("activate too soon after precharge");
   wr_rd_a: assert property (is_wr |=> !is_rd)
      else $error("read too soon after write");
   row_open_a: assert property (is_act |=> !is_pre [*3])
      else $error("row closed too early");
   mode_gap_a: assert property (is_mrs |=> quiet_s)
      else $error("command too soon after mode set");
   cke_hold_a: assert property ($changed(pins.cke) |=> $stable(pins.cke))
      else $error("clock enable pulse too short");
   exit_quiet_a: assert property ($rose(pins.cke) |=> quiet_s)
      else $error("command too soon after low power exit");
   urgent_ref_a: assert property ($past(refresh_urgent) && is_cmd |-> is_ref)
      else $error("non refresh command while refresh urgent");
   rdata_delay_a: assert property (mem_rdata_strobe |-> ##3 rdata_valid)
      else $error("read data valid late");
   freq_window_a: assert property ($fell(pins.cke) |-> ##[0:1] freq_change_ok)
      else $error("clock change window not flagged");
endmodule : lctg_guard_props
bind lctg_guard lctg_guard_props props_u (.clk(clk), .sys_rst(sys_rst),
   .refresh_urgent(refresh_urgent), .freq_change_ok(freq_change_ok),
   .rdata_valid(rdata_valid), .pins(pins), .mem_rdata_strobe(mem_rdata_strobe));

// File: tb/lctg_mem_model.sv
`timescale 1ns/1ps
module lctg_mem_model #(
   parameter int READ_LATENCY = 3
) (
   // Clock and reset.
   input wire logic                 clk,
   input wire logic                 sys_rst,
   // Command pins in, read strobe out.
   input wire lctg_pkg::lctg_pins_s pins,
   output logic                     mem_rdata_strobe
);
   logic [7:0] rd_pipe_r;
   wire logic  is_read = pins.cke && {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} == 4'h5;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_pipe_r <= 8'h00;
      end else begin
         rd_pipe_r <= {rd_pipe_r[6:0], is_read};
      end
   end
   // The strobe comes straight from the reset-cleared read pipe, so it sits low outside bursts.
   assign mem_rdata_strobe = rd_pipe_r[READ_LATENCY - 2];
endmodule : lctg_mem_model

// File: tb/test_lctg_guard.sv
`timescale 1ns/1ps
module test_lctg_guard;
   localparam int RL = 3;
   localparam int REFI = 40;
   localparam int ACT = lctg_pkg::LCTG_ACT, RD = lctg_pkg::LCTG_RD, WR = lctg_pkg::LCTG_WR;
   localparam int WRA = lctg_pkg::LCTG_WRA, PRE = lctg_pkg::LCTG_PRE, REF = lctg_pkg::LCTG_REF;
   localparam int SRE = lctg_pkg::LCTG_SRE, SRX = lctg_pkg::LCTG_SRX, PDE = lctg_pkg::LCTG_PDE;
   localparam int PDX = lctg_pkg::LCTG_PDX, MODE_REGISTER_SET = lctg_pkg::LCTG_MRS, STATUS_REGISTER_READ = lctg_pkg::LCTG_SRR;
   logic                 clk = 1'b0;
   logic                 sys_rst = 1'b1;
   logic                 req_valid = 1'b0;
   logic                 cke_seen = 1'b1;
   lctg_pkg::lctg_req_s  req = '0;
   lctg_pkg::lctg_pins_s pins;
   logic                 req_ready, refresh_urgent, row_timeout, freq_change_ok;
   logic                 rdata_valid, strobe;
   int                   cyc = 0, rel = 0, refs = 0, seed = 32'hCC65;
   int                   n_errors = 0, samples_checked = 0;
   int                   last [16];
   int                   rd_q [$];
   int                   seq [$] = '{ACT, WR, PRE, ACT, WR, RD, 0, PRE, 0, REF, ACT, WRA, ACT,
      RD, 0, PRE, 0, MODE_REGISTER_SET, STATUS_REGISTER_READ, ACT, PRE, 0, PDE, PDX, ACT, PRE, 0, SRE, SRX, MODE_REGISTER_SET};
   always #5 clk = ~clk;
   lctg_guard #(.READ_LATENCY(RL), .REFI_CYC(REFI), .RAS_MAX_CYC(100)) dut_u (
      .clk(clk), .sys_rst(sys_rst), .req(req), .req_valid(req_valid), .req_ready(req_ready),
      .refresh_urgent(refresh_urgent), .row_timeout(row_timeout),
      .freq_change_ok(freq_change_ok), .rdata_valid(rdata_valid), .pins(pins),
      .mem_rdata_strobe(strobe));
   lctg_mem_model #(.READ_LATENCY(RL)) mem_u (.clk(clk), .sys_rst(sys_rst), .pins(pins),
      .mem_rdata_strobe(strobe));
   task automatic cmp_cyc(input int got, input int exp);
      samples_checked++;
      if (got != exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : cmp_cyc
   task automatic cmp_flag(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : cmp_flag
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out
   // Minimum cycles from an issued command p to a following command n.
   function automatic int gap(input int p, input int n);
      if (p == REF) return 8;
      if (p == SRX) return 12;
      if (p == STATUS_REGISTER_READ) return RL + 1;
      if (p == PDX || p == MODE_REGISTER_SET) return 2;
      if (p inside {PDE, SRE} && n inside {PDX, SRX}) return 2;
      if (p == ACT) return (n == PRE) ? 4 : (n inside {RD, WR, WRA}) ? 2 : (n == ACT) ? 1 : 0;
      if (p == WRA) return (n == ACT) ? 4 : 0;
      if (p == PRE) return (n == ACT) ? 2 : 0;
      if (p == WR) return (n inside {PRE, RD}) ? 3 : 0;
      return 0;
   endfunction : gap
   function automatic int owed();
      return (cyc - rel) / REFI - refs;
   endfunction : owed
   task automatic send(input int c);
      int e;
      int w;
      repeat ($unsigned($random(seed)) % 3) @(posedge clk);
      @(posedge clk);
      #1;
      e = cyc + 1;
      foreach (last[p]) begin
         if (last[p] + gap(p, c) > e) e = last[p] + gap(p, c);
      end
      req.cmd = lctg_pkg::lctg_cmd_e'(c[3:0]);
      req_valid = 1'b1;
      w = 0;
      while (w < 40 && pins.cs_n === 1'b1 && pins.cke === cke_seen) begin
         @(posedge clk);
         #1;
         w++;
      end
      req_valid = 1'b0;
      cke_seen = pins.cke;
      cmp_cyc(cyc, e);
      last[c] = cyc;
      if (c == RD || c == STATUS_REGISTER_READ) rd_q.push_back(cyc + RL + 2);
      if (c == REF) refs++;
   endtask : send
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc > 3000) begin
         n_errors++;
         close_out();
      end
      if (rdata_valid === 1'b1) cmp_cyc(cyc, rd_q.size() > 0 ? rd_q.pop_front() : -1);
   end
   initial begin
      foreach (last[i]) last[i] = -100;
      repeat (5) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      rel = cyc;
      send(ACT);
      repeat (110) @(posedge clk);
      #1;
      cmp_flag(row_timeout, 1'b1);
      send(PRE);
      // The age clears one edge after the row closes and the flag one edge later.
      repeat (2) @(posedge clk);
      #1;
      cmp_flag(row_timeout, 1'b0);
      $display("row timeout test done");
      repeat (290 - (cyc - rel)) @(posedge clk);
      #1;
      cmp_flag(refresh_urgent, 1'b1);
      req.cmd = lctg_pkg::LCTG_ACT;
      req_valid = 1'b1;
      repeat (8) begin
         @(posedge clk);
         #1;
         cmp_flag(pins.cs_n, 1'b1);
      end
      req_valid = 1'b0;
      send(REF);
      @(posedge clk);
      #1;
      cmp_flag(refresh_urgent, 1'b0);
      while (owed() > 0) send(REF);
      $display("refresh backlog test done");
      // Idle slots cover gaps the controller may add beyond the modelled ones.
      foreach (seq[i]) begin
         if (seq[i] == 0) repeat (3) @(posedge clk);
         else send(seq[i]);
         if (seq[i] == PDE || seq[i] == SRE) begin
            @(posedge clk);
            #1;
            cmp_flag(freq_change_ok, 1'b1);
         end
      end
      repeat (10) @(posedge clk);
      cmp_cyc(rd_q.size(), 0);
      $display("command sequence test done");
      close_out();
   end
endmodule : test_lctg_guard
